//--- rtl/sms_core.sv
// Stepper motor settings core: step resolution, current, backlash, encoder and status report.
//
// Function
// - Step resolutions full to sixty-fourth plus adaptive microstep are selectable.
// - Each step moves full-step angle divided by the selected step fraction.
// - Adaptive mode coarsens steps with speed: 64th near 30 rpm, full near 3000.
// - Full-step angle is configurable, default 1.8 degrees, used for step angle.
// - Running phase current is a percentage in one percent units.
// - Idle motor receives the separate standstill current percentage.
// - Each direction reversal emits configured backlash steps before commanded steps.
// - Encoder reverse option swaps tracks A and B.
// - Auto status option sends status bytes unprompted at end of a run when no report is in progress.
`timescale 1ns/1ns
`default_nettype none
module sms_core (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst,
   // Settings.
   input  wire logic [3:0]  stepMode,
   input  wire logic [15:0] fullAngle,
   input  wire logic        angleLoad,
   input  wire logic [6:0]  runPct,
   input  wire logic [6:0]  idlePct,
   input  wire logic [15:0] backlashSteps,
   input  wire logic        encReverse,
   input  wire logic        autoStatus,
   // Motion commands from the profile generator.
   input  wire logic        cmdStep,
   input  wire logic        cmdDir,
   input  wire logic        running,
   input  wire logic [15:0] speedRpm,
   input  wire logic [15:0] statusWord,
   // Encoder pins.
   input  wire logic        encA,
   input  wire logic        encB,
   // Motor drive.
   output logic             stepOut,
   output logic             dirOut,
   output logic [6:0]       currentPct,
   output logic [6:0]       stepDiv,
   output logic [31:0]      microAngle,
   output logic [15:0]      angleCfg,
   // Position and encoder.
   output logic [31:0]      position,
   output logic [31:0]      encCount,
   // Status report to the serial link.
   output logic             txValid,
   output logic [7:0]       txByte,
   input  wire logic        txReady
);
   // Synchronisers for encoder pins.
   logic [1:0] encAS_q;
   logic [1:0] encBS_q;
   logic       trkAPrev_q;
   logic       trkBPrev_q;
   // Drive state.
   logic [15:0] angle_q;
   logic [15:0] blRemain_q;
   logic        lastDir_q;
   logic        moved_q;
   logic        pendStep_q;
   logic        stepOut_q;
   logic        dirOut_q;
   logic [31:0] position_q;
   logic [31:0] encCount_q;
   logic [6:0]  current_q;
   logic [6:0]  div_q;
   logic [31:0] micro_q;
   logic        runPrev_q;
   sms_pkg::sms_rpt_t rpt_q;
   logic [1:0]  rptCnt_q;
   logic [15:0] rptWord_q;

   // Effective resolution; adaptive mode picks by speed.
   logic [3:0] effMode;
   logic [6:0] divSel;
   assign effMode = (stepMode != sms_pkg::MODE_ADAPT) ? stepMode :
                    (speedRpm >= sms_pkg::RPM_COARSE) ? sms_pkg::MODE_FULL :
                    (speedRpm >= 16'(sms_pkg::RPM_COARSE - sms_pkg::RPM_STEP)) ? sms_pkg::MODE_HALF :
                    (speedRpm >= 16'(sms_pkg::RPM_STEP * 16'h0003)) ? sms_pkg::MODE_QUART :
                    (speedRpm >= sms_pkg::RPM_STEP) ? sms_pkg::MODE_EIGHT :
                    (speedRpm >= 16'(sms_pkg::RPM_FINE * 16'h0004)) ? sms_pkg::MODE_S16 :
                    (speedRpm > sms_pkg::RPM_FINE) ? sms_pkg::MODE_S32 : sms_pkg::MODE_S64;
   always_comb begin
      case (effMode)
         sms_pkg::MODE_FULL:  divSel = 7'h01;
         sms_pkg::MODE_HALF:  divSel = 7'h02;
         sms_pkg::MODE_QUART: divSel = 7'h04;
         sms_pkg::MODE_FIFTH: divSel = 7'h05;
         sms_pkg::MODE_EIGHT: divSel = 7'h08;
         sms_pkg::MODE_TENTH: divSel = 7'h0A;
         sms_pkg::MODE_S16:   divSel = 7'h10;
         sms_pkg::MODE_S32:   divSel = 7'h20;
         sms_pkg::MODE_S64:   divSel = 7'h40;
         default:             divSel = 7'h01;
      endcase
   end

   // Step angle in millionths of a degree per pulse.
   logic [31:0] microSel;
   assign microSel = (32'(angle_q) * 32'h0000_2710) / 32'(divSel);

   // Direction reversal, backlash, encoder decoding and run-end detection.
   logic reversal;
   logic blActive;
   logic encA2;
   logic encB2;
   logic trkA;
   logic trkB;
   logic prvA;
   logic prvB;
   logic encTick;
   logic encUp;
   logic runEnd;
   assign reversal = cmdStep && moved_q && !blActive && !pendStep_q &&
                     (cmdDir != lastDir_q) && (backlashSteps != 16'h0000);
   assign blActive = (blRemain_q != 16'h0000);
   assign encA2    = encAS_q[1];
   assign encB2    = encBS_q[1];
   assign trkA     = encReverse ? encB2 : encA2;
   assign trkB     = encReverse ? encA2 : encB2;
   // The previous samples are swapped with the same option, so toggling it adds no false count.
   assign prvA     = encReverse ? trkBPrev_q : trkAPrev_q;
   assign prvB     = encReverse ? trkAPrev_q : trkBPrev_q;
   assign encTick  = (trkA != prvA) || (trkB != prvB);
   assign encUp    = (trkA != prvA) ? (trkA != trkB) : (trkA == trkB);
   assign runEnd   = runPrev_q && !running;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         encAS_q    <= 2'h0;
         encBS_q    <= 2'h0;
         trkAPrev_q <= 1'b0;
         trkBPrev_q <= 1'b0;
         angle_q    <= sms_pkg::FULL_ANGLE_RST;
         blRemain_q <= 16'h0000;
         lastDir_q  <= 1'b0;
         moved_q    <= 1'b0;
         pendStep_q <= 1'b0;
         stepOut_q  <= 1'b0;
         dirOut_q   <= 1'b0;
         position_q <= 32'h0000_0000;
         encCount_q <= 32'h0000_0000;
         current_q  <= sms_pkg::IDLE_PCT_RST;
         div_q      <= 7'h01;
         micro_q    <= 32'h0000_0000;
         runPrev_q  <= 1'b0;
      end else begin
         encAS_q    <= {encAS_q[0], encA};
         encBS_q    <= {encBS_q[0], encB};
         trkAPrev_q <= encA2;
         trkBPrev_q <= encB2;
         runPrev_q  <= running;
         if (angleLoad) begin
            angle_q <= fullAngle;
         end
         div_q   <= divSel;
         micro_q <= microSel;
         current_q <= running ? ((runPct > sms_pkg::PCT_MAX) ? sms_pkg::PCT_MAX : runPct)
                              : ((idlePct > sms_pkg::PCT_MAX) ? sms_pkg::PCT_MAX : idlePct);
         if (encTick) begin
            encCount_q <= encUp ? encCount_q + 32'h1 : encCount_q - 32'h1;
         end
         stepOut_q <= 1'b0;
         if (reversal) begin
            blRemain_q <= backlashSteps;
            pendStep_q <= 1'b1;
            lastDir_q  <= cmdDir;
            dirOut_q   <= cmdDir;
         end else if (blActive && !stepOut_q) begin
            stepOut_q  <= 1'b1;
            blRemain_q <= blRemain_q - 16'h0001;
         end else if (pendStep_q && !blActive && !stepOut_q) begin
            stepOut_q  <= 1'b1;
            pendStep_q <= 1'b0;
            position_q <= lastDir_q ? position_q + 32'h1 : position_q - 32'h1;
         end else if (cmdStep && !blActive && !pendStep_q) begin
            stepOut_q  <= 1'b1;
            dirOut_q   <= cmdDir;
            lastDir_q  <= cmdDir;
            moved_q    <= 1'b1;
            position_q <= cmdDir ? position_q + 32'h1 : position_q - 32'h1;
         end
      end
   end

   // Automatic end-of-run status report, high byte first.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rpt_q     <= sms_pkg::RPT_IDLE;
         rptCnt_q  <= 2'h0;
         rptWord_q <= 16'h0000;
      end else begin
         case (rpt_q)
            sms_pkg::RPT_IDLE: begin
               if (runEnd && autoStatus) begin
                  rpt_q     <= sms_pkg::RPT_SEND;
                  rptCnt_q  <= sms_pkg::STAT_BYTES;
                  rptWord_q <= statusWord;
               end
            end
            sms_pkg::RPT_SEND: begin
               if (txReady) begin
                  rptWord_q <= {rptWord_q[7:0], 8'h00};
                  rptCnt_q  <= rptCnt_q - 2'h1;
                  if (rptCnt_q == 2'h1) begin
                     rpt_q <= sms_pkg::RPT_WAIT;
                  end
               end
            end
            sms_pkg::RPT_WAIT: rpt_q <= sms_pkg::RPT_IDLE;
            default:           rpt_q <= sms_pkg::RPT_IDLE;
         endcase
      end
   end

   assign txValid    = (rpt_q == sms_pkg::RPT_SEND);
   assign txByte     = rptWord_q[15:8];
   assign stepOut    = stepOut_q;
   assign dirOut     = dirOut_q;
   assign currentPct = current_q;
   assign stepDiv    = div_q;
   assign microAngle = micro_q;
   assign angleCfg   = angle_q;
   assign position   = position_q;
   assign encCount   = encCount_q;

   // Checks.
   sequence seqBlFirstPulse;
      (blRemain_q == $past(backlashSteps)) ##1 stepOut;
   endsequence
   chk_idle_current: assert property (@(posedge mclk) disable iff (rst)
      (!running && idlePct <= sms_pkg::PCT_MAX) |=> (currentPct == $past(idlePct)))
      else $error("Idle current not applied.");
   chk_run_current: assert property (@(posedge mclk) disable iff (rst)
      (running && runPct <= sms_pkg::PCT_MAX) |=> (currentPct == $past(runPct)))
      else $error("Run current not applied.");
   chk_fixed_div: assert property (@(posedge mclk) disable iff (rst)
      (stepMode == sms_pkg::MODE_S64) |=> (stepDiv == 7'h40))
      else $error("Sixty-fourth step divider wrong.");
   chk_adapt_fast: assert property (@(posedge mclk) disable iff (rst)
      (stepMode == sms_pkg::MODE_ADAPT && speedRpm >= sms_pkg::RPM_COARSE) |=> (stepDiv == 7'h01))
      else $error("Adaptive mode not full step at high speed.");
   chk_adapt_slow: assert property (@(posedge mclk) disable iff (rst)
      (stepMode == sms_pkg::MODE_ADAPT && speedRpm <= sms_pkg::RPM_FINE) |=> (stepDiv == 7'h40))
      else $error("Adaptive mode not fine at low speed.");
   chk_angle_load: assert property (@(posedge mclk) disable iff (rst)
      angleLoad |=> (angleCfg == $past(fullAngle)))
      else $error("Full-step angle not loaded.");
   chk_backlash_pos: assert property (@(posedge mclk) disable iff (rst)
      (blActive && !reversal) |=> $stable(position))
      else $error("Backlash step moved the position.");
   chk_backlash_start: assert property (@(posedge mclk) disable iff (rst)
      reversal |=> seqBlFirstPulse)
      else $error("Backlash steps not started on reversal.");
   chk_auto_report: assert property (@(posedge mclk) disable iff (rst)
      (runEnd && autoStatus && rpt_q == sms_pkg::RPT_IDLE) |=> txValid)
      else $error("Status report not started at run end.");
   chk_no_report: assert property (@(posedge mclk) disable iff (rst)
      (rpt_q == sms_pkg::RPT_IDLE && !(runEnd && autoStatus)) |=> !txValid)
      else $error("Unprompted report without run end.");
endmodule
`default_nettype wire

//--- rtl/sms_pkg.sv
// Package with constants and types of the stepper motor settings core.
package sms_pkg;
   // Step resolution codes.
   typedef enum logic [3:0] {
      MODE_FULL  = 4'h0,
      MODE_HALF  = 4'h1,
      MODE_QUART = 4'h2,
      MODE_FIFTH = 4'h3,
      MODE_EIGHT = 4'h4,
      MODE_TENTH = 4'h5,
      MODE_S16   = 4'h6,
      MODE_S32   = 4'h7,
      MODE_S64   = 4'h8,
      MODE_ADAPT = 4'h9
   } sms_mode_t;
   // Full-step angle in hundredths of a degree.
   localparam logic [15:0] FULL_ANGLE_RST = 16'h00B4;
   // Phase current reset values in percent.
   localparam logic [6:0]  RUN_PCT_RST    = 7'h0A;
   localparam logic [6:0]  IDLE_PCT_RST   = 7'h0A;
   localparam logic [6:0]  PCT_MAX        = 7'h64;
   // Adaptive thresholds on speed in rpm.
   localparam logic [15:0] RPM_FINE       = 16'h001E;
   localparam logic [15:0] RPM_COARSE     = 16'h0BB8;
   localparam logic [15:0] RPM_STEP       = 16'h0258;
   // Number of status bytes sent after a run.
   localparam logic [1:0]  STAT_BYTES     = 2'h2;
   // Report state machine.
   typedef enum logic [1:0] {
      RPT_IDLE = 2'b00,
      RPT_SEND = 2'b01,
      RPT_WAIT = 2'b10
   } sms_rpt_t;
endpackage

//--- bench/sms_motor_model.sv
// Motor and incremental encoder model that follows the step and direction outputs.
`timescale 1ns/1ns
`default_nettype none
module sms_motor_model (
   // Drive from the core.
   input  wire logic mclk,
   input  wire logic stepOut,
   input  wire logic dirOut,
   // Encoder tracks.
   output logic      encA,
   output logic      encB
);
   logic [1:0] phase_q = 2'h0;
   always @(posedge mclk) begin
      if (stepOut === 1'b1) begin
         phase_q <= dirOut ? phase_q + 2'h1 : phase_q - 2'h1;
      end
   end
   assign encA = phase_q[1];
   assign encB = phase_q[1] ^ phase_q[0];
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench of the stepper motor settings core.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        mclk, rst, angleLoad, encReverse, autoStatus, cmdStep, cmdDir, running, txReady;
   logic        stepOut, dirOut, txValid, encA, encB;
   logic [3:0]  stepMode;
   logic [15:0] fullAngle, backlashSteps, speedRpm, statusWord, angleCfg;
   logic [6:0]  runPct, idlePct, currentPct, stepDiv;
   logic [31:0] microAngle, position, encCount;
   logic [7:0]  txByte;
   logic [7:0]  rx[$];
   int          fail_count = 0, total_checks = 0, pulses = 0, pos = 0, ang, d1, p;
   int          divs[9] = '{1, 2, 4, 5, 8, 10, 16, 32, 64};
   int          rpms[7] = '{3000, 2400, 1800, 600, 120, 31, 30};
   int          adiv[7] = '{1, 2, 4, 8, 16, 32, 64};
   sms_core dut_u (
      .mclk(mclk), .rst(rst), .stepMode(stepMode), .fullAngle(fullAngle), .angleLoad(angleLoad),
      .runPct(runPct), .idlePct(idlePct), .backlashSteps(backlashSteps), .encReverse(encReverse),
      .autoStatus(autoStatus), .cmdStep(cmdStep), .cmdDir(cmdDir), .running(running), .speedRpm(speedRpm),
      .statusWord(statusWord), .encA(encA), .encB(encB), .stepOut(stepOut), .dirOut(dirOut),
      .currentPct(currentPct), .stepDiv(stepDiv), .microAngle(microAngle), .angleCfg(angleCfg),
      .position(position), .encCount(encCount), .txValid(txValid), .txByte(txByte), .txReady(txReady)
   );
   sms_motor_model motor_u (.mclk(mclk), .stepOut(stepOut), .dirOut(dirOut), .encA(encA), .encB(encB));
   always @(posedge mclk) begin
      if (stepOut === 1'b1) begin
         pulses <= pulses + 1;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic step(input logic dir, input int expPulses);
      int p0;
      p0 = pulses;
      cmdStep <= 1'b1;
      cmdDir <= dir;
      tick(1);
      cmdStep <= 1'b0;
      tick(14);
      pos = dir ? pos + 1 : pos - 1;
      check(pulses - p0, expPulses);
      check(position, pos);
      check(dirOut, dir);
   endtask
   task automatic finish_test;
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(77647));
      rst = 1'b1;
      stepMode = 4'h1;
      fullAngle = 16'h00B4;
      angleLoad = 1'b0;
      runPct = 7'h32;
      idlePct = 7'h0A;
      backlashSteps = 16'h0000;
      encReverse = 1'b0;
      autoStatus = 1'b0;
      cmdStep = 1'b0;
      cmdDir = 1'b1;
      running = 1'b0;
      speedRpm = 16'h0000;
      statusWord = 16'h0000;
      txReady = 1'b0;
      tick(16);
      check(angleCfg, 32'h00B4);
      check(position, 32'h0);
      check(txValid, 32'h0);
      rst <= 1'b0;
      for (int a = 0; a < 2; a++) begin
         ang = a ? 4 * (1 + $urandom % 150) : 180;
         fullAngle <= ang[15:0];
         angleLoad <= 1'b1;
         tick(1);
         angleLoad <= 1'b0;
         for (int m = 0; m < 9; m++) begin
            stepMode <= m[3:0];
            tick(3);
            check(angleCfg, ang);
            check(stepDiv, divs[m]);
            check(microAngle, ang * 10000 / divs[m]);
         end
      end
      stepMode <= 4'h9;
      for (int i = 0; i < 7; i++) begin
         speedRpm <= rpms[i][15:0];
         tick(3);
         check(stepDiv, adiv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         runPct <= 7'($urandom);
         idlePct <= 7'($urandom);
         running <= i[0];
         tick(3);
         p = i[0] ? runPct : idlePct;
         check(currentPct, p > 100 ? 100 : p);
      end
      stepMode <= 4'h1;
      repeat (4) step(1'b1, 1);
      d1 = encCount;
      check(d1 == 4 || d1 == -4, 1);
      encReverse <= 1'b1;
      p = encCount;
      repeat (4) step(1'b1, 1);
      check(encCount - p, -d1);
      encReverse <= 1'b0;
      backlashSteps <= 16'h0003;
      step(1'b0, 4);
      step(1'b0, 1);
      step(1'b1, 4);
      for (int r = 0; r < 2; r++) begin
         // Auto status is enabled only while this drive is alone on the link.
         autoStatus <= r[0];
         statusWord <= 16'($urandom);
         running <= 1'b1;
         tick(2);
         running <= 1'b0;
         rx.delete();
         repeat (30) begin
            @(negedge mclk);
            if (txValid === 1'b1 && txReady === 1'b1) begin
               rx.push_back(txByte);
            end
            @(posedge mclk);
            txReady <= 1'($urandom);
         end
         check(rx.size(), r ? 2 : 0);
         if (rx.size() == 2) begin
            check(rx[0], statusWord[15:8]);
            check(rx[1], statusWord[7:0]);
         end
         check(txValid, 32'h0);
      end
      finish_test();
   end
endmodule
`default_nettype wire
